// File: pcx_regs.svh
// Register addresses, reset values, field positions and signal slots
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

// Special-function register addresses
`define PCX_ADDR_P0_LATCH   8'h80
`define PCX_ADDR_P1_LATCH   8'h90
`define PCX_ADDR_P0_DRIVE   8'ha4
`define PCX_ADDR_P1_INPUT   8'had
`define PCX_ADDR_ROUTE_A    8'he1
`define PCX_ADDR_ROUTE_B    8'he2
`define PCX_ADDR_ROUTE_C    8'he3
`define PCX_ADDR_ROUTE_D    8'he4

// Reset values
`define PCX_RST_LATCH       8'hff
`define PCX_RST_DRIVE       8'h00
`define PCX_RST_INPUT       8'hff
`define PCX_RST_ROUTE       8'h00

// Writable masks: unused and reserved bits stay zero
`define PCX_ROUTE_C_WMASK   8'hdf
`define PCX_ROUTE_D_WMASK   8'h8f

// Route A fields
`define PCX_RA_CP0          7
`define PCX_RA_ECI          6
`define PCX_RA_PCA_HI       5
`define PCX_RA_PCA_LO       3
`define PCX_RA_UART_A       2
`define PCX_RA_SPI          1
`define PCX_RA_TWO_WIRE     0
// Route B fields
`define PCX_RB_SYSCK        7
`define PCX_RB_T2_RELOAD    6
`define PCX_RB_T2_COUNT     5
`define PCX_RB_IRQ1         4
`define PCX_RB_T1_COUNT     3
`define PCX_RB_IRQ0         2
`define PCX_RB_T0_COUNT     1
`define PCX_RB_CP1          0
// Route C fields
`define PCX_RC_PULLUP_OFF   7
`define PCX_RC_XBAR_ON      6
`define PCX_RC_T4_RELOAD    4
`define PCX_RC_T4_COUNT     3
`define PCX_RC_UART_B       2
`define PCX_RC_LOW_PORT     1
`define PCX_RC_CONV_A       0
// Route D fields
`define PCX_RD_CAN_PP       7
`define PCX_RD_CP2          3
`define PCX_RD_CONV_C       2
`define PCX_RD_T3_RELOAD    1
`define PCX_RD_T3_COUNT     0

// Port 0 pins owned by memory strobes
`define PCX_PIN_ALE         5
`define PCX_PIN_RD          6
`define PCX_PIN_WR          7
`define PCX_PORT_W          8

// Peripheral signal slots in priority order (0 is highest)
`define PCX_NSIG            33
`define PCX_SIG_TXA         6'h00
`define PCX_SIG_RXA         6'h01
`define PCX_SIG_SCK         6'h02
`define PCX_SIG_MISO        6'h03
`define PCX_SIG_MOSI        6'h04
`define PCX_SIG_NSS         6'h05
`define PCX_SIG_SDA         6'h06
`define PCX_SIG_SCL         6'h07
`define PCX_SIG_TXB         6'h08
`define PCX_SIG_RXB         6'h09
`define PCX_SIG_COUNTER_MODULE_LINE_ZERO        6'h0a
`define PCX_SIG_ECI         6'h10
`define PCX_SIG_CP0         6'h11
`define PCX_SIG_CP1         6'h12
`define PCX_SIG_T0          6'h13
`define PCX_SIG_IRQ0        6'h14
`define PCX_SIG_T1          6'h15
`define PCX_SIG_IRQ1        6'h16
`define PCX_SIG_T2          6'h17
`define PCX_SIG_T2_RELOAD   6'h18
`define PCX_SIG_T4          6'h19
`define PCX_SIG_T4_RELOAD   6'h1a
`define PCX_SIG_SYSCK       6'h1b
`define PCX_SIG_CONV_A      6'h1c
`define PCX_SIG_CP2         6'h1d
`define PCX_SIG_CONV_C      6'h1e
`define PCX_SIG_T3          6'h1f
`define PCX_SIG_T3_RELOAD   6'h20
`define PCX_CEX_LINES       6

`endif

// File: pcx_pkg.sv
// Types shared by the crossbar and its pin drivers
package pcx_pkg;
  // Who sets the level of a pin
  typedef enum logic [1:0] {
    PCX_SRC_LATCH,
    PCX_SRC_XBAR,
    PCX_SRC_MEMIF
  } pcx_src_t;
  // Index of a peripheral signal slot
  typedef logic [5:0] pcx_sig_t;
endpackage : pcx_pkg

// File: pcx_pin_driver.sv
// One port pin output stage with registered level, enable and pullup
`timescale 1ns/100ps
module pcx_pin_driver (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic            ce,
  // Source selection
  input  wire pcx_pkg::pcx_src_t src,
  input  wire logic            xbar_on,
  input  wire logic            xbar_val,
  input  wire logic            xbar_drive,
  input  wire logic            force_od,
  input  wire logic            memif_val,
  input  wire logic            memif_drive,
  input  wire logic            latch_bit,
  input  wire logic            push_pull,
  input  wire logic            analog,
  input  wire logic            pullup_off,
  // Pin side
  output logic                 pin_out,
  output logic                 pin_oe,
  output logic                 pin_pullup
);
  logic next_level;  // Level the pin should show
  logic next_oe;     // Driver enable for that level

  // Pick the level from the owner of the pin
  always_comb
  begin
    case (src)
      pcx_pkg::PCX_SRC_XBAR:  next_level = xbar_drive ? xbar_val : 1'b1;
      pcx_pkg::PCX_SRC_MEMIF: next_level = memif_drive ? memif_val
                                                       : latch_bit;
      pcx_pkg::PCX_SRC_LATCH: next_level = latch_bit;
      default:                next_level = latch_bit;
    endcase
    // A high level floats unless push-pull and not forced open-drain; disabled crossbar means input
    next_oe = xbar_on && (!next_level || (push_pull && !force_od));
  end

  // Registered so pins whose owner is unchanged never glitch
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_out    <= 1'b1;
      pin_oe     <= 1'b0;
      pin_pullup <= 1'b1;
    end
    else if (ce)
    begin
      pin_out    <= next_level;
      pin_oe     <= next_oe;
      pin_pullup <= !pullup_off && !analog && !next_oe;
    end
  end

  // Open-drain high never drives
  od_high_float_a: assert property (@(posedge ref_clk) disable iff (reset)
    ce && (force_od || !push_pull) && next_level |=> !pin_oe)
    else $error("open-drain pin drove a high level");
  analog_no_pull_a: assert property (@(posedge ref_clk)
    disable iff (reset) ce && analog |=> !pin_pullup)
    else $error("analog pin kept its pullup");
endmodule : pcx_pin_driver

// File: pcx_crossbar.sv
// Port 0/1 crossbar, latches, drive and input modes
`timescale 1ns/100ps
`include "pcx_regs.svh"
module pcx_crossbar #(
  parameter int NSIG = `PCX_NSIG,  // Peripheral signal slots
  parameter int NPIN = 16          // Ports 0 and 1
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic            ce,
  // Special-function register port
  input  wire logic [7:0]      sfr_addr,
  input  wire logic [7:0]      sfr_wdata,
  input  wire logic            sfr_wr,
  input  wire logic            sfr_rd,
  output logic [7:0]           sfr_rdata,
  output logic                 sfr_hit,
  // Package pins, port 1 in the upper byte
  input  wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0]      pin_out,
  output logic [NPIN-1:0]      pin_oe,
  output logic [NPIN-1:0]      pin_pullup,
  // Peripheral signals by slot
  input  wire logic [NSIG-1:0] periph_out,
  input  wire logic [NSIG-1:0] periph_drive,
  output logic [NSIG-1:0]      periph_in,
  // Peripheral modes
  input  wire logic            spi_three_wire,
  input  wire logic            uart_a_mode0,
  input  wire logic            uart_b_mode0,
  // Memory interface
  input  wire logic            memif_nonmux_mode_bit,
  input  wire logic [2:0]      memif_strobe_val,
  input  wire logic [2:0]      memif_strobe_drive,
  input  wire logic [7:0]      memif_addr_val,
  input  wire logic            memif_addr_drive,
  // Status
  output logic                 can_tx_drive_select
);
  // Software registers
  logic [7:0] port_zero_latch;         // Port 0 output latch
  logic [7:0] port_one_latch;          // Port 1 output latch
  logic [7:0] port_zero_drive_select;  // 1 = push-pull
  logic [7:0] port_one_input_select;   // 0 = analog input
  logic [7:0] crossbar_route_a;
  logic [7:0] crossbar_route_b;
  logic [7:0] crossbar_route_c;
  logic [7:0] crossbar_route_d;

  // Allocation state
  logic [NSIG-1:0] sig_en;             // Enabled signal slots
  logic [5:0]      sig_rank [NSIG];    // Enabled slots ahead of each
  logic [5:0]      pin_ord  [NPIN];    // Free pins ahead of each pin
  logic [NPIN-1:0] pin_skip;           // Pins the crossbar passes over
  logic [NPIN-1:0] pin_valid;          // Pin carries a peripheral
  pcx_pkg::pcx_sig_t pin_sel [NPIN];   // Slot on each pin
  logic [5:0]      cnt_sig;
  logic [5:0]      cnt_pin;
  logic [2:0]      cex_count;
  logic            crossbar_active;
  logic            memif_low_port_select;
  logic            global_pullup_disable;
  logic [NSIG-1:0] next_periph_in;

  // Per-pin driver inputs
  pcx_pkg::pcx_src_t pin_src [NPIN];
  logic [NPIN-1:0] xval;
  logic [NPIN-1:0] xdrv;
  logic [NPIN-1:0] fod;
  logic [NPIN-1:0] mval;
  logic [NPIN-1:0] mdrv;
  logic [NPIN-1:0] latch_all;
  logic [NPIN-1:0] push_all;
  logic [NPIN-1:0] analog_all;

  assign crossbar_active       = crossbar_route_c[`PCX_RC_XBAR_ON];
  assign memif_low_port_select = crossbar_route_c[`PCX_RC_LOW_PORT];
  assign global_pullup_disable = crossbar_route_c[`PCX_RC_PULLUP_OFF];
  assign cex_count  = crossbar_route_a[`PCX_RA_PCA_HI:`PCX_RA_PCA_LO];
  assign can_tx_drive_select = crossbar_route_d[`PCX_RD_CAN_PP];
  assign latch_all  = {port_one_latch, port_zero_latch};
  // Port 1 drive mode lives elsewhere; its pins are open-drain here
  assign push_all   = {8'h00, port_zero_drive_select};
  assign analog_all = {~port_one_input_select, 8'h00};

  // Address decode; unmapped addresses leave the bus to other blocks
  always_comb
  begin
    case (sfr_addr)
      `PCX_ADDR_P0_LATCH, `PCX_ADDR_P1_LATCH, `PCX_ADDR_P0_DRIVE,
      `PCX_ADDR_P1_INPUT, `PCX_ADDR_ROUTE_A, `PCX_ADDR_ROUTE_B,
      `PCX_ADDR_ROUTE_C, `PCX_ADDR_ROUTE_D: sfr_hit = 1'b1;
      default:                              sfr_hit = 1'b0;
    endcase
  end

  // Register writes
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      port_zero_latch        <= `PCX_RST_LATCH;
      port_one_latch         <= `PCX_RST_LATCH;
      port_zero_drive_select <= `PCX_RST_DRIVE;
      port_one_input_select  <= `PCX_RST_INPUT;
      crossbar_route_a       <= `PCX_RST_ROUTE;
      crossbar_route_b       <= `PCX_RST_ROUTE;
      crossbar_route_c       <= `PCX_RST_ROUTE;
      crossbar_route_d       <= `PCX_RST_ROUTE;
    end
    else if (ce && sfr_wr)
    begin
      case (sfr_addr)
        `PCX_ADDR_P0_LATCH: port_zero_latch        <= sfr_wdata;
        `PCX_ADDR_P1_LATCH: port_one_latch         <= sfr_wdata;
        `PCX_ADDR_P0_DRIVE: port_zero_drive_select <= sfr_wdata;
        `PCX_ADDR_P1_INPUT: port_one_input_select  <= sfr_wdata;
        `PCX_ADDR_ROUTE_A:  crossbar_route_a       <= sfr_wdata;
        `PCX_ADDR_ROUTE_B:  crossbar_route_b       <= sfr_wdata;
        // Unused bit dropped on write
        `PCX_ADDR_ROUTE_C:
          crossbar_route_c <= sfr_wdata & `PCX_ROUTE_C_WMASK;
        // Reserved bits are read-only zero
        `PCX_ADDR_ROUTE_D:
          crossbar_route_d <= sfr_wdata & `PCX_ROUTE_D_WMASK;
        default: ;
      endcase
    end
  end

  // Read data, registered; port reads see pins, not latches
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      sfr_rdata <= 8'h00;
    else if (ce && sfr_rd)
    begin
      case (sfr_addr)
        `PCX_ADDR_P0_LATCH: sfr_rdata <= pin_in[7:0];
        `PCX_ADDR_P1_LATCH:
          sfr_rdata <= pin_in[15:8] & port_one_input_select;
        `PCX_ADDR_P0_DRIVE: sfr_rdata <= port_zero_drive_select;
        `PCX_ADDR_P1_INPUT: sfr_rdata <= port_one_input_select;
        `PCX_ADDR_ROUTE_A:  sfr_rdata <= crossbar_route_a;
        `PCX_ADDR_ROUTE_B:  sfr_rdata <= crossbar_route_b;
        `PCX_ADDR_ROUTE_C:  sfr_rdata <= crossbar_route_c;
        `PCX_ADDR_ROUTE_D:  sfr_rdata <= crossbar_route_d;
        default:            sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Enable bits to signal slots
  always_comb
  begin
    sig_en = '0;
    sig_en[`PCX_SIG_TXA]  = crossbar_route_a[`PCX_RA_UART_A];
    sig_en[`PCX_SIG_RXA]  = crossbar_route_a[`PCX_RA_UART_A];
    sig_en[`PCX_SIG_SCK]  = crossbar_route_a[`PCX_RA_SPI];
    sig_en[`PCX_SIG_MISO] = crossbar_route_a[`PCX_RA_SPI];
    sig_en[`PCX_SIG_MOSI] = crossbar_route_a[`PCX_RA_SPI];
    sig_en[`PCX_SIG_NSS]  = crossbar_route_a[`PCX_RA_SPI]
                            && !spi_three_wire;
    sig_en[`PCX_SIG_SDA]  = crossbar_route_a[`PCX_RA_TWO_WIRE];
    sig_en[`PCX_SIG_SCL]  = crossbar_route_a[`PCX_RA_TWO_WIRE];
    sig_en[`PCX_SIG_TXB]  = crossbar_route_c[`PCX_RC_UART_B];
    sig_en[`PCX_SIG_RXB]  = crossbar_route_c[`PCX_RC_UART_B];
    // Count n enables lines zero to n-1; codes above six route all six
    for (int i = 0; i < `PCX_CEX_LINES; i++)
      sig_en[`PCX_SIG_COUNTER_MODULE_LINE_ZERO + i] = (cex_count > 3'(i));
    sig_en[`PCX_SIG_ECI]  = crossbar_route_a[`PCX_RA_ECI];
    sig_en[`PCX_SIG_CP0]  = crossbar_route_a[`PCX_RA_CP0];
    sig_en[`PCX_SIG_CP1]  = crossbar_route_b[`PCX_RB_CP1];
    sig_en[`PCX_SIG_T0]   = crossbar_route_b[`PCX_RB_T0_COUNT];
    sig_en[`PCX_SIG_IRQ0] = crossbar_route_b[`PCX_RB_IRQ0];
    sig_en[`PCX_SIG_T1]   = crossbar_route_b[`PCX_RB_T1_COUNT];
    sig_en[`PCX_SIG_IRQ1] = crossbar_route_b[`PCX_RB_IRQ1];
    sig_en[`PCX_SIG_T2]   = crossbar_route_b[`PCX_RB_T2_COUNT];
    sig_en[`PCX_SIG_T2_RELOAD] = crossbar_route_b[`PCX_RB_T2_RELOAD];
    sig_en[`PCX_SIG_T4]   = crossbar_route_c[`PCX_RC_T4_COUNT];
    sig_en[`PCX_SIG_T4_RELOAD] = crossbar_route_c[`PCX_RC_T4_RELOAD];
    sig_en[`PCX_SIG_SYSCK] = crossbar_route_b[`PCX_RB_SYSCK];
    sig_en[`PCX_SIG_CONV_A] = crossbar_route_c[`PCX_RC_CONV_A];
    sig_en[`PCX_SIG_CP2]  = crossbar_route_d[`PCX_RD_CP2];
    sig_en[`PCX_SIG_CONV_C] = crossbar_route_d[`PCX_RD_CONV_C];
    sig_en[`PCX_SIG_T3]   = crossbar_route_d[`PCX_RD_T3_COUNT];
    sig_en[`PCX_SIG_T3_RELOAD] = crossbar_route_d[`PCX_RD_T3_RELOAD];
  end

  // Skipped pins: memory strobes on port 0, analog pins on port 1
  always_comb
  begin
    pin_skip = analog_all;
    if (memif_low_port_select)
    begin
      pin_skip[`PCX_PIN_WR] = 1'b1;
      pin_skip[`PCX_PIN_RD] = 1'b1;
      pin_skip[`PCX_PIN_ALE] = !memif_nonmux_mode_bit;
    end
  end

  // Priority allocation: k-th enabled slot takes k-th free pin
  always_comb
  begin
    cnt_sig = 6'h00;
    cnt_pin = 6'h00;
    for (int k = 0; k < NSIG; k++)
    begin
      sig_rank[k] = cnt_sig;
      if (sig_en[k])
        cnt_sig = cnt_sig + 6'h01;
    end
    for (int p = 0; p < NPIN; p++)
    begin
      pin_ord[p] = cnt_pin;
      if (!pin_skip[p])
        cnt_pin = cnt_pin + 6'h01;
    end
    // Slots past the last pin of port 1 fall to ports out of scope
    for (int p = 0; p < NPIN; p++)
    begin
      pin_valid[p] = 1'b0;
      pin_sel[p]   = 6'h00;
      for (int k = 0; k < NSIG; k++)
        if (!pin_skip[p] && sig_en[k] && sig_rank[k] == pin_ord[p])
        begin
          pin_valid[p] = 1'b1;
          pin_sel[p]   = 6'(k);
        end
    end
  end

  // Per-pin owner, levels and forced open-drain
  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      mval[p] = 1'b1;
      mdrv[p] = 1'b0;
      xval[p] = periph_out[pin_sel[p]];
      xdrv[p] = periph_drive[pin_sel[p]];
      if (pin_sel[p] == `PCX_SIG_SYSCK)
      begin
        xval[p] = !periph_out[pin_sel[p]];
        xdrv[p] = 1'b1;
      end
      fod[p] = pin_valid[p] && (pin_sel[p] == `PCX_SIG_SDA
               || pin_sel[p] == `PCX_SIG_SCL
               || (pin_sel[p] == `PCX_SIG_RXA && uart_a_mode0)
               || (pin_sel[p] == `PCX_SIG_RXB && uart_b_mode0));
      if (p < `PCX_PORT_W && memif_low_port_select && pin_skip[p])
      begin
        pin_src[p] = pcx_pkg::PCX_SRC_MEMIF;
        mval[p] = memif_strobe_val[p - `PCX_PIN_ALE];
        mdrv[p] = memif_strobe_drive[p - `PCX_PIN_ALE];
      end
      else if (p >= `PCX_PORT_W && memif_low_port_select
               && memif_nonmux_mode_bit && memif_addr_drive)
      begin
        pin_src[p] = pcx_pkg::PCX_SRC_MEMIF;
        mval[p] = memif_addr_val[p - `PCX_PORT_W];
        mdrv[p] = 1'b1;
      end
      else if (pin_valid[p])
        pin_src[p] = pcx_pkg::PCX_SRC_XBAR;
      else
        pin_src[p] = pcx_pkg::PCX_SRC_LATCH;
    end
  end

  // Pin levels back to the peripherals; idle high when unrouted
  always_comb
  begin
    next_periph_in = '1;
    for (int p = 0; p < NPIN; p++)
      if (pin_valid[p] && crossbar_active)
        next_periph_in[pin_sel[p]] = pin_in[p];
  end

  // Peripheral inputs registered to stay glitch free
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      periph_in <= '1;
    else if (ce)
      periph_in <= next_periph_in;
  end

  // One output stage per pin
  for (genvar g = 0; g < NPIN; g++)
  begin : g_pin
    pcx_pin_driver u_drv (
      .ref_clk     (ref_clk),
      .reset       (reset),
      .ce          (ce),
      .src         (pin_src[g]),
      .xbar_on     (crossbar_active),
      .xbar_val    (xval[g]),
      .xbar_drive  (xdrv[g]),
      .force_od    (fod[g]),
      .memif_val   (mval[g]),
      .memif_drive (mdrv[g]),
      .latch_bit   (latch_all[g]),
      .push_pull   (push_all[g]),
      .analog      (analog_all[g]),
      .pullup_off  (global_pullup_disable),
      .pin_out     (pin_out[g]),
      .pin_oe      (pin_oe[g]),
      .pin_pullup  (pin_pullup[g])
    );
  end

  // Checks
  xbar_off_input_a: assert property (@(posedge ref_clk) disable iff (reset)
    ce && !crossbar_active |=> pin_oe == '0)
    else $error("pin driven while crossbar disabled");
  unused_bit_zero_a: assert property (@(posedge ref_clk)
    disable iff (reset) crossbar_route_c[5] == 1'b0)
    else $error("unused route C bit set");
  reserved_zero_a: assert property (@(posedge ref_clk)
    disable iff (reset) crossbar_route_d[6:4] == 3'h0)
    else $error("reserved route D bits set");
  uart_a_fixed_a: assert property (@(posedge ref_clk) disable iff (reset)
    crossbar_route_a[`PCX_RA_UART_A] |-> pin_sel[0] == `PCX_SIG_TXA
    && pin_sel[1] == `PCX_SIG_RXA && pin_valid[1:0] == 2'h3)
    else $error("serial port A not on pins 0.0 and 0.1");
  mux_skip_a: assert property (@(posedge ref_clk) disable iff (reset)
    memif_low_port_select && !memif_nonmux_mode_bit
    |-> pin_valid[7:5] == 3'h0)
    else $error("strobe pin allocated in multiplexed mode");
  nonmux_ale_free_a: assert property (@(posedge ref_clk)
    disable iff (reset) memif_low_port_select && memif_nonmux_mode_bit
    |-> !pin_skip[`PCX_PIN_ALE] && pin_valid[7:6] == 2'h0)
    else $error("wrong strobe skip in non-multiplexed mode");
  analog_skip_a: assert property (@(posedge ref_clk) disable iff (reset)
    (pin_valid[15:8] & ~port_one_input_select) == 8'h00)
    else $error("analog pin allocated");
  analog_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    ce && sfr_rd && sfr_addr == `PCX_ADDR_P1_LATCH
    |=> (sfr_rdata & ~$past(port_one_input_select)) == 8'h00)
    else $error("analog port bit read nonzero");
  no_cex_a: assert property (@(posedge ref_clk) disable iff (reset)
    cex_count == 3'h0 |-> sig_en[15:10] == 6'h00)
    else $error("module line routed with count zero");
  three_wire_a: assert property (@(posedge ref_clk) disable iff (reset)
    spi_three_wire |-> !sig_en[`PCX_SIG_NSS])
    else $error("slave select allocated in three-wire mode");
  write_reach_a: assert property (@(posedge ref_clk) disable iff (reset)
    ce && sfr_wr && sfr_addr == `PCX_ADDR_ROUTE_C
    && !sfr_wdata[`PCX_RC_XBAR_ON] ##1 ce |=> pin_oe == '0)
    else $error("crossbar disable late at pins");

  // Main scenarios
  cov_uart_a: cover property (@(posedge ref_clk) disable iff (reset)
    crossbar_active && pin_valid[0]);
  cov_mux_low: cover property (@(posedge ref_clk) disable iff (reset)
    memif_low_port_select && !memif_nonmux_mode_bit && pin_valid[8]);
  cov_analog: cover property (@(posedge ref_clk) disable iff (reset)
    port_one_input_select != 8'hff && |pin_valid[15:8]);
endmodule : pcx_crossbar

// File: pcx_pad_model.sv
// Board-side model of the port pads and whatever drives them from outside
`timescale 1ns/100ps
module pcx_pad_model (
  // Clock
  input  wire logic        ref_clk,
  // Device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pin_pullup,
  // Board side
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  output logic [15:0]      pin_in
);
  logic [15:0] last = 16'h0000;  // Previous pad levels
  // Device driver wins, then board, then pullup; a bare pad wanders so
  // that a floating line is never mistaken for a steady level
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | ~last));
  // Remember each cycle's levels
  always_ff @(posedge ref_clk) last <= pin_in;
endmodule : pcx_pad_model

// File: testbench.sv
// Self-checking bench for the port crossbar
`timescale 1ns/100ps
`include "pcx_regs.svh"
module testbench;
  logic        ref_clk = 1'h0, reset = 1'h1, wr_s = 1'h0, rd_s = 1'h0;
  logic        mode = 1'h0, can_transmit_pin;  // Non-multiplexed select, CAN drive
  logic        ce = 1'h1, u0m = 1'h0, hit;  // Enable, serial A mode 0
  logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat;
  logic [15:0] pin_in, pin_out, pin_oe, pin_pu;
  logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000;
  logic [32:0] p_out = 33'h1ffffffff, p_drv = 33'h000000000, p_in;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  logic [7:0]  ra [8] = '{`PCX_ADDR_P0_LATCH, `PCX_ADDR_P1_LATCH,
    `PCX_ADDR_P0_DRIVE, `PCX_ADDR_P1_INPUT, `PCX_ADDR_ROUTE_A,
    `PCX_ADDR_ROUTE_B, `PCX_ADDR_ROUTE_C, `PCX_ADDR_ROUTE_D};
  logic [7:0]  rv [8] = '{8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00};
  // Clock at 100 MHz
  always #5 ref_clk = ~ref_clk;
  pcx_crossbar dut (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .sfr_addr(addr), .sfr_wdata(wdat), .sfr_wr(wr_s), .sfr_rd(rd_s),
    .sfr_rdata(rdat), .sfr_hit(hit), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pu), .periph_out(p_out),
    .periph_drive(p_drv), .periph_in(p_in), .spi_three_wire(mode),
    .uart_a_mode0(u0m), .uart_b_mode0(1'h0),
    .memif_nonmux_mode_bit(mode), .memif_strobe_val(3'h0),
    .memif_strobe_drive(3'h0), .memif_addr_val(8'h00),
    .memif_addr_drive(1'h0), .can_tx_drive_select(can_transmit_pin));
  pcx_pad_model pads (.ref_clk(ref_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pu), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  // Compare and count
  task automatic chk(string nm, logic [32:0] exp, logic [32:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One-cycle register write; a quiet edge follows so strobes never
  // drop and rise again in one time step
  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdat = d;
    wr_s = 1'h1;
    @(posedge ref_clk);
    #1 wr_s = 1'h0;
    @(posedge ref_clk);
    #1;
  endtask : wr
  // One-cycle register read; data is registered behind the strobe
  task automatic rd(logic [7:0] a, logic [7:0] e);
    addr = a;
    rd_s = 1'h1;
    @(posedge ref_clk);
    #1 rd_s = 1'h0;
    @(posedge ref_clk);
    #1;
    chk("read", e, rdat);
  endtask : rd
  // Pins follow a write one edge later and peripheral inputs one edge after that; wait three edges
  task automatic step();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : step
  // Report counts and end the run
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'h0;
    chk("oe", 16'h0000, pin_oe);
    foreach (ra[i]) rd(ra[i], rv[i]);
    chk("hit", 1'h1, hit);
    rd(8'h81, 8'h00);
    chk("hit", 1'h0, hit);
    wr(`PCX_ADDR_ROUTE_C, 8'hff);
    rd(`PCX_ADDR_ROUTE_C, 8'hdf);
    wr(`PCX_ADDR_ROUTE_D, 8'hff);
    rd(`PCX_ADDR_ROUTE_D, 8'h8f);
    chk("ctx", 1'h1, can_transmit_pin);
    wr(`PCX_ADDR_ROUTE_D, 8'h00);
    chk("ctx", 1'h0, can_transmit_pin);
    // Serial port A on the two lowest pins
    wr(`PCX_ADDR_ROUTE_C, 8'h40);
    wr(`PCX_ADDR_ROUTE_A, 8'h04);
    p_out[0] = 1'h0;
    p_drv[0] = 1'h1;
    ext_en[1] = 1'h1;
    step();
    chk("tx", 2'h2, {pin_oe[0], pin_out[0]});
    chk("rx", 1'h0, p_in[1]);
    rd(`PCX_ADDR_P0_LATCH, 8'hfc);
    // Latch levels and drive modes
    wr(`PCX_ADDR_P0_LATCH, 8'hfb);
    step();
    chk("lo", 2'h2, {pin_oe[2], pin_out[2]});
    chk("od", 1'h0, pin_oe[3]);
    // Receive line stays open-drain in mode 0 even when push-pull
    u0m = 1'h1;
    wr(`PCX_ADDR_P0_DRIVE, 8'h0a);
    step();
    chk("pp", 2'h3, {pin_oe[3], pin_out[3]});
    chk("fod", 1'h0, pin_oe[1]);
    // A write with the clock enable low must not land
    ce = 1'h0;
    wr(`PCX_ADDR_P0_DRIVE, 8'h00);
    ce = 1'h1;
    rd(`PCX_ADDR_P0_DRIVE, 8'h0a);
    chk("pu", 1'h1, pin_pu[4]);
    wr(`PCX_ADDR_ROUTE_C, 8'hc0);
    step();
    chk("pu", 1'h0, pin_pu[4]);
    // Analog input on the first port 1 pin
    wr(`PCX_ADDR_ROUTE_C, 8'h40);
    ext_en = 16'h0100;
    ext_val = 16'h0100;
    wr(`PCX_ADDR_P1_INPUT, 8'hfe);
    step();
    rd(`PCX_ADDR_P1_LATCH, 8'hfe);
    chk("apu", 1'h0, pin_pu[8]);
    wr(`PCX_ADDR_P1_INPUT, 8'hff);
    step();
    rd(`PCX_ADDR_P1_LATCH, 8'hff);
    // Six module lines behind serial A, memory strobes skipped
    p_drv = 33'h000000000;
    ext_en = 16'h0300;
    ext_val = 16'h0000;
    wr(`PCX_ADDR_ROUTE_A, 8'h34);
    wr(`PCX_ADDR_ROUTE_C, 8'h42);
    step();
    chk("mux", 1'h0, p_in[13]);
    mode = 1'h1;
    step();
    chk("nmx", 3'h1, {p_in[15], p_in[14], p_in[13]});
    wr(`PCX_ADDR_ROUTE_A, 8'h2c);
    step();
    chk("cnt", 1'h1, p_in[15]);
    // Slave select dropped in three-wire mode, placed past skips otherwise
    ext_en = 16'h0320;
    wr(`PCX_ADDR_ROUTE_A, 8'h06);
    step();
    chk("nss3", 1'h1, p_in[`PCX_SIG_NSS]);
    mode = 1'h0;
    step();
    chk("nss", 1'h0, p_in[`PCX_SIG_NSS]);
    wr(`PCX_ADDR_ROUTE_C, 8'h00);
    step();
    chk("off", 16'h0000, pin_oe);
    give_verdict();
  end
endmodule : testbench
